/* File: src/uart_channel_irq.sv */
// channel interrupt enable, prioritised status and line status logic
// Notes on behaviour
// - enable bits mask rx, tx, line and modem sources from being pending
// - rx interrupt: data held in non-fifo mode, trigger reached in fifo mode
// - fifo mode rx status and interrupt drop when level falls below trigger
// - line status bit 0 shows receive data present, clears when empty
// - fifo on with enables 3:0 clear gives polled operation via line status
// - bit 1 overrun, bits 4:2 top byte error, bit 7 any fifo error
// - bit 5 holding or fifo empty, bit 6 fifo and shift register empty
// - enable 7 with enhance bit: interrupt on clear-to-send low to high
// - enable 6 with enhance bit: interrupt on request-to-send low to high
// - enable 5 writable only with enhance bit; enable 4 reserved
// - modem interrupt when any delta bit sets and enable 3 set
// - line interrupt on faulty char, again when it reaches fifo top
// - per-char error bits show only the top byte; fifo error otherwise
// - tx interrupt on empty; fifo mode below trigger and again on empty
// - auto half-duplex delays second tx interrupt until shifter empty
// - status read returns highest pending source, others wait
// - receive time-out after four characters plus twelve bit times
// - flow pin edges only with auto flow enables; select picks pin pair
// - line clear on line read, rx below trigger, time-out on data read
// - tx clear on status read or data write; modem and pins on modem read
// - xon/xoff clear on status read; special also on next character
// - status code encoding by priority, 000001 means none
// - status bits 7:6 both follow fifo enable
// - status bit 0 low while pending, high when none, high at reset
//
// Decided for this implementation: the register offsets and the APB register port.
module uart_channel_irq
   import uart_irq_pkg::*;
#(
   parameter int CHAR_BITS = 10,
   parameter int TMR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] rx_data,
   input wire logic rx_has_data,
   input wire logic rx_at_trigger,
   input wire logic rx_char_done,
   input wire logic rx_char_error,
   input wire logic rx_top_advance,
   input wire logic [2:0] rx_top_error,
   input wire logic rx_overrun,
   input wire logic rx_fifo_error,
   input wire logic tx_holding_empty,
   input wire logic tx_below_trigger,
   input wire logic tx_shift_empty,
   input wire logic bit_tick,
   input wire logic xon_detected,
   input wire logic xoff_detected,
   input wire logic special_detected,
   input wire logic rts_level,
   input wire logic dtr_level,
   input wire logic cts_pin_n,
   input wire logic dsr_pin_n,
   input wire logic ri_pin_n,
   input wire logic cd_pin_n,
   output logic irq,
   output logic rx_pop,
   output logic tx_push,
   output logic [7:0] tx_data,
   output logic fifo_enable,
   output logic [7:0] modem_control,
   output logic [7:0] enhanced_feature,
   output logic [7:0] feature_control
);
   localparam int TIMEOUT_BITS = TIMEOUT_CHARS * CHAR_BITS + TIMEOUT_EXTRA_BITS;
   localparam logic [TMR_W-1:0] TIMEOUT_END = TMR_W'(TIMEOUT_BITS - 1);

   logic [7:0] interrupt_enable_reg;
   logic [3:0] pins;
   logic [3:0] pins_prev;
   logic [3:0] modem_delta;
   logic [1:0] out_prev;
   logic [2:0] tx_prev;
   logic line_flag, overrun_flag, tx_flag, timeout_flag;
   logic flowchar_flag, special_flag, flowpin_flag;
   logic line_seen, pin_seen;
   logic [TMR_W-1:0] timer;
   logic setup, rd_done, wr_done, mapped;
   logic [3:0] idx;
   logic [5:0] code;
   logic [7:0] interrupt_status_reg, line_status_reg, modem_status_reg;
   logic [7:0] pend;
   logic line_set, tx_set, pin_set, timer_end;
   logic [3:0] pin_change;

   // pins from outside: order cts, dsr, ri, cd
   pin_sync #(.WIDTH(4)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in({cd_pin_n, ri_pin_n, dsr_pin_n, cts_pin_n}),
      .pin_sync_out(pins)
   );

   // bus phases
   assign setup = psel & ~penable;
   assign rd_done = psel & penable & pready & ~pwrite;
   assign wr_done = psel & penable & pready & pwrite;
   assign idx = paddr[5:2];
   assign mapped = (paddr[7:6] == 2'b00) &&
      (idx inside {IDX_HOLDING, IDX_ENABLE, IDX_STATUS, IDX_MODEM_CTRL,
                   IDX_LINE_STATUS, IDX_MODEM_STATUS, IDX_FEATURE_CTRL, IDX_ENHANCED});

   // pending sources; rx, time-out, tx, line and modem gated by their enables here, flow flags gated when set
   always_comb
   begin
      pend = 8'h00;
      pend[0] = interrupt_enable_reg[ENA_LINE] & line_flag;
      pend[1] = interrupt_enable_reg[ENA_RX] &
         (fifo_enable ? rx_at_trigger : rx_has_data);
      pend[2] = interrupt_enable_reg[ENA_RX] & timeout_flag;
      pend[3] = interrupt_enable_reg[ENA_TX] & tx_flag;
      pend[4] = interrupt_enable_reg[ENA_MODEM] & (|modem_delta);
      pend[5] = flowchar_flag;
      pend[6] = flowpin_flag;
   end

   // highest priority source wins; lower ones stay queued
   always_comb
   begin
      if (pend[0]) code = CODE_LINE;
      else if (pend[1]) code = CODE_RX;
      else if (pend[2]) code = CODE_TIMEOUT;
      else if (pend[3]) code = CODE_TX;
      else if (pend[4]) code = CODE_MODEM;
      else if (pend[5]) code = CODE_FLOWCHAR;
      else if (pend[6]) code = CODE_FLOWPIN;
      else code = CODE_NONE;
   end

   // read views
   assign interrupt_status_reg = {{2{fifo_enable}}, code};
   assign line_status_reg = {rx_fifo_error, tx_holding_empty & tx_shift_empty, tx_holding_empty,
      rx_top_error, overrun_flag, rx_has_data};
   assign modem_status_reg = {~pins[3], ~pins[2], ~pins[1], ~pins[0], modem_delta};

   // read data and error flag are latched in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= RDATA_RST;
         pslverr <= 1'b0;
         line_seen <= 1'b0;
         pin_seen <= 1'b0;
      end
      else if (setup)
      begin
         pslverr <= ~mapped;
         line_seen <= line_flag;
         pin_seen <= flowpin_flag;
         prdata <= RDATA_RST;
         if (mapped && !pwrite)
         begin
            unique case (idx)
               IDX_HOLDING: prdata[7:0] <= rx_data;
               IDX_ENABLE: prdata[7:0] <= interrupt_enable_reg;
               IDX_STATUS: prdata[7:0] <= interrupt_status_reg;
               IDX_MODEM_CTRL: prdata[7:0] <= modem_control;
               IDX_LINE_STATUS: prdata[7:0] <= line_status_reg;
               IDX_MODEM_STATUS: prdata[7:0] <= modem_status_reg;
               IDX_FEATURE_CTRL: prdata[7:0] <= feature_control;
               IDX_ENHANCED: prdata[7:0] <= enhanced_feature;
               default: prdata[7:0] <= 8'h00;
            endcase
         end
      end
   end

   // no wait state: ready rises in the first access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= setup;
   end

   // software-written control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         interrupt_enable_reg <= ENABLE_RST;
         fifo_enable <= 1'b0;
         modem_control <= CTRL_RST;
         enhanced_feature <= CTRL_RST;
         feature_control <= CTRL_RST;
      end
      else if (wr_done && !pslverr)
      begin
         unique case (idx)
            IDX_ENABLE:
            begin
               // upper enables only move while the enhance bit is set
               if (enhanced_feature[EFR_ENHANCE])
                  interrupt_enable_reg[7:5] <= pwdata[7:5];
               interrupt_enable_reg[4] <= 1'b0;
               interrupt_enable_reg[3:0] <= pwdata[3:0];
            end
            IDX_STATUS: fifo_enable <= pwdata[FCR_FIFO_EN];
            IDX_MODEM_CTRL: modem_control <= pwdata[7:0];
            IDX_FEATURE_CTRL: feature_control <= pwdata[7:0];
            IDX_ENHANCED: enhanced_feature <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // datapath strobes for holding register access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_pop <= 1'b0;
         tx_push <= 1'b0;
         tx_data <= 8'h00;
      end
      else
      begin
         rx_pop <= rd_done && idx == IDX_HOLDING && !pslverr;
         tx_push <= wr_done && idx == IDX_HOLDING && !pslverr;
         if (wr_done && idx == IDX_HOLDING && !pslverr)
            tx_data <= pwdata[7:0];
      end
   end

   // line status interrupt: immediate, and again when the bad byte is on top
   assign line_set = (rx_char_done & rx_char_error) | rx_overrun |
      (rx_top_advance & (|rx_top_error));
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         line_flag <= 1'b0;
         overrun_flag <= 1'b0;
      end
      else
      begin
         // only what the read saw is cleared, so a late event survives
         line_flag <= line_set |
            (line_flag & ~(rd_done && idx == IDX_LINE_STATUS && line_seen));
         overrun_flag <= rx_overrun |
            (overrun_flag & ~(rd_done && idx == IDX_LINE_STATUS && prdata[1]));
      end
   end

   // tx ready on empty; fifo mode also below trigger, rs485 waits for shifter
   always_comb
   begin
      if (!fifo_enable)
         tx_set = tx_holding_empty & ~tx_prev[0];
      else if (feature_control[FEATURE_CONTROL_REG_AUTO485])
         tx_set = (tx_below_trigger & ~tx_prev[1]) |
            (tx_holding_empty & tx_shift_empty & ~tx_prev[2]);
      else
         tx_set = (tx_below_trigger & ~tx_prev[1]) |
            (tx_holding_empty & ~tx_prev[0]);
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_prev <= 3'b111;
         tx_flag <= 1'b0;
      end
      else
      begin
         tx_prev <= {tx_holding_empty & tx_shift_empty, tx_below_trigger, tx_holding_empty};
         tx_flag <= tx_set | (tx_flag & ~((rd_done && idx == IDX_STATUS && prdata[5:0] == CODE_TX) ||
            (wr_done && idx == IDX_HOLDING)));
      end
   end

   // receive time-out counts bit times while data waits unread
   assign timer_end = bit_tick && timer == TIMEOUT_END;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer <= '0;
         timeout_flag <= 1'b0;
      end
      else
      begin
         if (rx_char_done || rx_pop || !rx_has_data || !fifo_enable || timer_end)
            timer <= '0;
         else if (bit_tick)
            timer <= timer + 1'b1;
         timeout_flag <= (timer_end & fifo_enable) | (timeout_flag & ~rx_pop);
      end
   end

   // modem deltas: any change on cts, dsr, cd; ring on its trailing edge
   assign pin_change = {pins[3] ^ pins_prev[3], pins[2] & ~pins_prev[2],
      pins[1] ^ pins_prev[1], pins[0] ^ pins_prev[0]};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pins_prev <= 4'hF;
         modem_delta <= 4'h0;
      end
      else
      begin
         pins_prev <= pins;
         modem_delta <= pin_change |
            (modem_delta & ~((rd_done && idx == IDX_MODEM_STATUS) ? prdata[3:0] : 4'h0));
      end
   end

   // flow pin edges, gated by enables and auto flow, pair chosen by select
   assign pin_set = enhanced_feature[EFR_ENHANCE] &
      ((interrupt_enable_reg[ENA_CTS] & enhanced_feature[EFR_AUTO_CTS] &
        (modem_control[MCR_FLOW_SEL] ? (pins[1] & ~pins_prev[1]) : (pins[0] & ~pins_prev[0]))) |
       (interrupt_enable_reg[ENA_RTS] & enhanced_feature[EFR_AUTO_RTS] &
        (modem_control[MCR_FLOW_SEL] ? (dtr_level & ~out_prev[1]) : (rts_level & ~out_prev[0]))));
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_prev <= 2'b11;
         flowpin_flag <= 1'b0;
      end
      else
      begin
         out_prev <= {dtr_level, rts_level};
         flowpin_flag <= pin_set |
            (flowpin_flag & ~(rd_done && idx == IDX_MODEM_STATUS && pin_seen));
      end
   end

   // xon, xoff and special character
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flowchar_flag <= 1'b0;
         special_flag <= 1'b0;
      end
      else
      begin
         if ((xon_detected | xoff_detected | special_detected) && interrupt_enable_reg[ENA_XOFF])
         begin
            flowchar_flag <= 1'b1;
            special_flag <= special_detected;
         end
         else if ((rd_done && idx == IDX_STATUS && prdata[5:0] == CODE_FLOWCHAR) ||
                  (special_flag && rx_char_done))
         begin
            flowchar_flag <= 1'b0;
            special_flag <= 1'b0;
         end
      end
   end

   // interrupt output follows the pending set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |pend;
   end

   // checks
   mask_line_a: assert property (@(posedge pclk) disable iff (!presetn)
      !interrupt_enable_reg[ENA_LINE] |-> code != CODE_LINE)
      else $error("masked line source reported");
   rx_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      interrupt_enable_reg[ENA_RX] && fifo_enable && rx_at_trigger && !pend[0] |-> code == CODE_RX)
      else $error("rx trigger not reported");
   trig_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      fifo_enable && !rx_at_trigger |-> code != CODE_RX)
      else $error("rx status held below trigger");
   line_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_done && idx == IDX_LINE_STATUS && line_seen && !line_set |=> !line_flag)
      else $error("line flag survived its read");
   fifo_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && idx == IDX_STATUS && mapped |=> prdata[7:6] == {2{$past(fifo_enable)}})
      else $error("status fifo bits wrong");
   irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 irq == $past(|pend))
      else $error("irq does not follow pending");
   none_code_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pend == 8'h00) == (code == CODE_NONE))
      else $error("none code mismatch");
   timeout_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_end && fifo_enable |=> timeout_flag)
      else $error("time-out not raised");
   upper_en_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_done && idx == IDX_ENABLE && !enhanced_feature[EFR_ENHANCE] |=> $stable(interrupt_enable_reg[7:5]))
      else $error("upper enables moved without enhance");
   cts_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      pin_set |=> flowpin_flag)
      else $error("flow pin edge lost");
   bus_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready)
      else $error("ready not one cycle after setup");
   cov_line_c: cover property (@(posedge pclk) disable iff (!presetn) line_set ##[1:20] code == CODE_LINE);
   cov_tx_c: cover property (@(posedge pclk) disable iff (!presetn) tx_set && fifo_enable);
   cov_timeout_c: cover property (@(posedge pclk) disable iff (!presetn) timeout_flag ##1 rx_pop);
   cov_pin_c: cover property (@(posedge pclk) disable iff (!presetn) flowpin_flag && irq);
endmodule

/* File: inc/uart_irq_pkg.sv */
// constants for the channel interrupt and line status logic
package uart_irq_pkg;
   // register indices; the byte address is four times the index
   localparam logic [3:0] IDX_HOLDING = 4'h0;
   localparam logic [3:0] IDX_ENABLE = 4'h1;
   localparam logic [3:0] IDX_STATUS = 4'h2;
   localparam logic [3:0] IDX_MODEM_CTRL = 4'h4;
   localparam logic [3:0] IDX_LINE_STATUS = 4'h5;
   localparam logic [3:0] IDX_MODEM_STATUS = 4'h6;
   localparam logic [3:0] IDX_FEATURE_CTRL = 4'h8;
   localparam logic [3:0] IDX_ENHANCED = 4'h9;
   // interrupt enable bit positions
   localparam int ENA_RX = 0;
   localparam int ENA_TX = 1;
   localparam int ENA_LINE = 2;
   localparam int ENA_MODEM = 3;
   localparam int ENA_XOFF = 5;
   localparam int ENA_RTS = 6;
   localparam int ENA_CTS = 7;
   // control bit positions
   localparam int EFR_ENHANCE = 4;
   localparam int EFR_AUTO_RTS = 6;
   localparam int EFR_AUTO_CTS = 7;
   localparam int FEATURE_CONTROL_REG_AUTO485 = 5;
   localparam int MCR_FLOW_SEL = 2;
   localparam int FCR_FIFO_EN = 0;
   // status source codes, bits 5:0
   localparam logic [5:0] CODE_LINE = 6'h06;
   localparam logic [5:0] CODE_RX = 6'h04;
   localparam logic [5:0] CODE_TIMEOUT = 6'h0C;
   localparam logic [5:0] CODE_TX = 6'h02;
   localparam logic [5:0] CODE_MODEM = 6'h00;
   localparam logic [5:0] CODE_FLOWCHAR = 6'h10;
   localparam logic [5:0] CODE_FLOWPIN = 6'h20;
   localparam logic [5:0] CODE_NONE = 6'h01;
   // reset values
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [31:0] RDATA_RST = 32'h00000000;
   // receive time-out: four characters plus twelve bit times
   localparam int TIMEOUT_CHARS = 4;
   localparam int TIMEOUT_EXTRA_BITS = 12;
endpackage

/* File: src/pin_sync.sv */
// two-stage synchroniser for a group of asynchronous pins
module pin_sync #(
   parameter int WIDTH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync_out
);
   genvar i;
   // one synchroniser per pin; stage one feeds stage two only
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_sync
         logic stage_one;
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               stage_one <= 1'b1;
               pin_sync_out[i] <= 1'b1;
            end
            else
            begin
               stage_one <= pin_in[i];
               pin_sync_out[i] <= stage_one;
            end
         end
      end
   endgenerate
endmodule

/* File: verif/uart_side_model.sv */
// behavioural receive fifo standing behind the channel interrupt logic
module uart_side_model #(
   parameter int TRIG = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic push,
   input wire logic push_err,
   input wire logic [7:0] push_byte,
   input wire logic rx_pop,
   output logic [7:0] rx_data,
   output logic rx_has_data,
   output logic rx_at_trigger,
   output logic rx_char_done,
   output logic rx_char_error,
   output logic rx_top_advance,
   output logic [2:0] rx_top_error,
   output logic rx_fifo_error
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [8:0] q[$];
   logic any_err;
   // one queue update per edge; level, top byte and fifo error outputs follow the new contents
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q = {};
         rx_data <= 8'h00;
         rx_has_data <= 1'b0;
         rx_at_trigger <= 1'b0;
         rx_char_done <= 1'b0;
         rx_char_error <= 1'b0;
         rx_top_advance <= 1'b0;
         rx_top_error <= 3'h0;
         rx_fifo_error <= 1'b0;
      end
      else
      begin
         rx_top_advance <= 1'b0;
         if (rx_pop && q.size() > 0)
         begin
            void'(q.pop_front());
            rx_top_advance <= (q.size() > 0);
         end
         if (push)
         begin
            if (q.size() == 0)
               rx_top_advance <= 1'b1;
            q.push_back({push_err, push_byte});
         end
         any_err = 1'b0;
         foreach (q[k])
            any_err = any_err | q[k][8];
         rx_char_done <= push;
         rx_char_error <= push & push_err;
         rx_has_data <= (q.size() > 0);
         rx_at_trigger <= (q.size() >= TRIG);
         // an empty fifo holds no steady byte: rx_data inverts on every edge
         rx_data <= (q.size() > 0) ? q[0][7:0] : ~rx_data;
         rx_top_error <= (q.size() > 0 && q[0][8]) ? 3'h1 : 3'h0;
         rx_fifo_error <= any_err;
      end
   end
endmodule

/* File: verif/uart_channel_irq_test.sv */
// register-level tests of the channel interrupt logic over apb
module uart_channel_irq_test;
   import uart_irq_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, irq, rx_pop, tx_push, fifo_enable;
   logic [7:0] rx_data, tx_data, modem_control, enhanced_feature, feature_control;
   logic rx_has_data, rx_at_trigger, rx_char_done, rx_char_error, rx_top_advance, rx_fifo_error;
   logic [2:0] rx_top_error;
   logic push = 0, push_err = 0, tx_he = 0, tx_bt = 0, tx_se = 0, xflow = 0, rts = 0, cts_n = 1, dsr_n = 1;
   logic [7:0] push_byte = 8'h00;
   logic [1:0] tick_cnt = 2'h0;
   int num_errors = 0, n_tests = 0;
   always #5 pclk = ~pclk;
   // bit time every fourth clock keeps the time-out counter moving
   always @(posedge pclk)
      tick_cnt <= tick_cnt + 2'h1;
   uart_channel_irq u_uart_channel_irq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_data(rx_data), .rx_has_data(rx_has_data), .rx_at_trigger(rx_at_trigger), .rx_char_done(rx_char_done),
      .rx_char_error(rx_char_error), .rx_top_advance(rx_top_advance), .rx_top_error(rx_top_error),
      .rx_overrun(1'b0), .rx_fifo_error(rx_fifo_error), .tx_holding_empty(tx_he), .tx_below_trigger(tx_bt),
      .tx_shift_empty(tx_se), .bit_tick(tick_cnt == 2'h3), .xon_detected(xflow), .xoff_detected(xflow),
      .special_detected(1'b0), .rts_level(rts), .dtr_level(1'b0), .cts_pin_n(cts_n), .dsr_pin_n(dsr_n),
      .ri_pin_n(1'b1), .cd_pin_n(1'b1), .irq(irq), .rx_pop(rx_pop), .tx_push(tx_push), .tx_data(tx_data),
      .fifo_enable(fifo_enable), .modem_control(modem_control), .enhanced_feature(enhanced_feature),
      .feature_control(feature_control));
   uart_side_model u_uart_side_model (.pclk(pclk), .presetn(presetn), .push(push), .push_err(push_err),
      .push_byte(push_byte), .rx_pop(rx_pop), .rx_data(rx_data), .rx_has_data(rx_has_data),
      .rx_at_trigger(rx_at_trigger), .rx_char_done(rx_char_done), .rx_char_error(rx_char_error),
      .rx_top_advance(rx_top_advance), .rx_top_error(rx_top_error), .rx_fifo_error(rx_fifo_error));
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_bit(input string name, input logic exp, input logic got);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %b seen %b", name, exp, got);
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 50)
         num_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask
   task automatic rd(input logic [3:0] idx, input logic [7:0] exp, input string name);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 8'h00, r, e);
      chk8(name, exp, r[7:0]);
   endtask
   task automatic settle();
      repeat (4) @(posedge pclk);
   endtask
   task automatic rx_char(input logic [7:0] b, input logic e);
      @(posedge pclk);
      push <= 1'b1;
      push_err <= e;
      push_byte <= b;
      @(posedge pclk);
      push <= 1'b0;
      settle();
   endtask
   // a run still going at 200000 ns ends through the same report, counted as a mismatch
   initial
   begin
      #200000;
      num_errors++;
      final_report();
   end
   initial
   begin
      logic [31:0] r;
      logic e;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(IDX_STATUS, 8'h01, "status reset");
      rd(IDX_ENABLE, ENABLE_RST, "enable reset");
      apb(1'b0, 4'hF, 8'h00, r, e);
      chk_bit("unmapped error", 1'b1, e);
      $display("test reset done");
      // masked source stays silent, polled flags still work
      rx_char(8'h3C, 1'b0);
      rd(IDX_STATUS, 8'h01, "masked rx");
      chk_bit("irq masked", 1'b0, irq);
      rd(IDX_LINE_STATUS, 8'h01, "polled data ready");
      wr(IDX_ENABLE, 8'h01);
      settle();
      rd(IDX_STATUS, 8'h04, "rx held");
      chk_bit("irq rx", 1'b1, irq);
      rd(IDX_HOLDING, 8'h3C, "holding byte");
      settle();
      rd(IDX_STATUS, 8'h01, "rx emptied");
      chk_bit("irq idle", 1'b0, irq);
      $display("test rx done");
      // fifo mode trigger of two characters
      wr(IDX_STATUS, 8'h01);
      rx_char(8'h11, 1'b0);
      rd(IDX_STATUS, 8'hC1, "below trigger");
      repeat (220) @(posedge pclk);
      rd(IDX_STATUS, 8'hCC, "time-out");
      rx_char(8'h22, 1'b0);
      rd(IDX_STATUS, 8'hC4, "at trigger");
      rd(IDX_HOLDING, 8'h11, "fifo byte 1");
      settle();
      rd(IDX_STATUS, 8'hC1, "fell below");
      rd(IDX_HOLDING, 8'h22, "fifo byte 2");
      wr(IDX_STATUS, 8'h00);
      settle();
      rd(IDX_STATUS, 8'h01, "fifo off");
      $display("test fifo done");
      // faulty byte behind a clean one
      wr(IDX_ENABLE, 8'h05);
      rx_char(8'h55, 1'b0);
      rx_char(8'hAA, 1'b1);
      rd(IDX_STATUS, 8'h06, "line first");
      rd(IDX_LINE_STATUS, 8'h81, "fifo error only");
      rd(IDX_STATUS, 8'h04, "rx queued");
      rd(IDX_HOLDING, 8'h55, "clean byte");
      settle();
      rd(IDX_STATUS, 8'h06, "line again");
      rd(IDX_LINE_STATUS, 8'h85, "parity at top");
      rd(IDX_HOLDING, 8'hAA, "faulty byte");
      settle();
      rd(IDX_STATUS, 8'h01, "line served");
      $display("test line done");
      // transmit empty event and flags
      wr(IDX_ENABLE, 8'h02);
      tx_he <= 1'b1;
      settle();
      rd(IDX_STATUS, 8'h02, "tx ready");
      rd(IDX_STATUS, 8'h01, "tx cleared");
      rd(IDX_LINE_STATUS, 8'h20, "holding empty");
      tx_se <= 1'b1;
      settle();
      rd(IDX_LINE_STATUS, 8'h60, "all empty");
      wr(IDX_STATUS, 8'h01);
      wr(IDX_FEATURE_CTRL, 8'h20);
      tx_he <= 1'b0;
      tx_se <= 1'b0;
      settle();
      chk8("feature out", 8'h20, feature_control);
      tx_he <= 1'b1;
      settle();
      rd(IDX_STATUS, 8'hC1, "rs485 waits");
      tx_se <= 1'b1;
      settle();
      chk_bit("rs485 irq", 1'b1, irq);
      wr(IDX_HOLDING, 8'h5A);
      @(posedge pclk);
      chk_bit("tx push", 1'b1, tx_push);
      chk8("tx byte", 8'h5A, tx_data);
      rd(IDX_STATUS, 8'hC1, "tx write clear");
      wr(IDX_STATUS, 8'h00);
      $display("test tx done");
      // upper enables gated by the enhance bit
      wr(IDX_ENABLE, 8'hFF);
      rd(IDX_ENABLE, 8'h0F, "enable gated");
      wr(IDX_ENABLE, 8'h00);
      wr(IDX_ENHANCED, 8'h50);
      wr(IDX_ENABLE, 8'hFF);
      rd(IDX_ENABLE, 8'hEF, "enable open");
      wr(IDX_ENABLE, 8'h60);
      @(posedge pclk);
      xflow <= 1'b1;
      @(posedge pclk);
      xflow <= 1'b0;
      settle();
      rd(IDX_STATUS, 8'h10, "flow char");
      rd(IDX_STATUS, 8'h01, "flow char read");
      rts <= 1'b1;
      settle();
      rd(IDX_STATUS, 8'h20, "rts rise");
      rd(IDX_MODEM_STATUS, 8'h00, "modem no delta");
      rd(IDX_STATUS, 8'h01, "pin served");
      wr(IDX_ENABLE, 8'h00);
      wr(IDX_ENHANCED, 8'h00);
      $display("test flow done");
      // modem deltas from two pins
      wr(IDX_ENABLE, 8'h08);
      cts_n <= 1'b0;
      dsr_n <= 1'b0;
      settle();
      rd(IDX_STATUS, 8'h00, "modem pending");
      chk_bit("irq modem", 1'b1, irq);
      rd(IDX_MODEM_STATUS, 8'h33, "modem deltas");
      rd(IDX_STATUS, 8'h01, "modem served");
      $display("test modem done");
      final_report();
   end
endmodule
